/* File: cfg_menu_pkg.sv */
// Purpose: types of the configuration menu controller
// Assumes: nothing
// Notes:   constants live in cfg_menu_regs.svh
package cfg_menu_pkg;

    typedef enum logic [2:0] {
        MODE_SETUP, MODE_BATCH, MODE_OPTION, MODE_TEST, MODE_END
    } mode_e;

    typedef enum logic [3:0] {
        ST_IDLE, ST_MODE, ST_CLEAR, ST_SCALE, ST_RATE_DP, ST_TIMEBASE,
        ST_FILTER, ST_DIVISOR, ST_TOT_DP, ST_ACC_DP, ST_ACCESS,
        ST_OTHER
    } step_e;

    typedef enum logic [1:0] {
        TB_SEC, TB_MIN, TB_HOUR, TB_DAY
    } timebase_e;

    typedef struct packed {
        logic run;
        logic display;
        logic batch_set;
        logic stop;
        logic total;
        logic reset;
    } keys_s;

    typedef struct packed {
        logic run;
        logic display;
        logic batch_set;
        logic stop;
    } lamps_s;

    typedef struct packed {
        logic [3:0]  step;
        logic        show_value;
        logic        flash;
        logic [2:0]  digit;
        logic [2:0]  mode;
    } panel_s;

endpackage : cfg_menu_pkg

/* File: cfg_menu_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz mclk, Avalon-MM word addressing in bytes
// Notes:   definitions only
`ifndef CFG_MENU_REGS_SVH
`define CFG_MENU_REGS_SVH

`define CLK_HZ            100000000
`define HOLD_TIME_S       6
`define HOLD_CYCLES       (`HOLD_TIME_S * `CLK_HZ)
`define FLASH_TIME_MS     250
`define FLASH_CYCLES      (`FLASH_TIME_MS * (`CLK_HZ / 1000))

`define ADDR_CTRL         4'h0
`define ADDR_STATUS       4'h1
`define ADDR_SCALE        4'h2
`define ADDR_RATE_DP      4'h3
`define ADDR_TIMEBASE     4'h4
`define ADDR_FILTER       4'h5
`define ADDR_DIVISOR      4'h6
`define ADDR_TOT_DP       4'h7
`define ADDR_ACC_DP       4'h8

`define CTRL_KEYS_OFF_BIT 0

`define SCALE_RESET       24'h000001
`define FILTER_RESET      7'h01
`define DIVISOR_RESET     24'h000100
`define DIVISOR_MIN       24'h000001
`define DIVISOR_MAX       24'h030D40
`define FILTER_MIN        7'h01
`define FILTER_MAX        7'h63
`define RATE_DP_MAX       3'h4
`define TOT_DP_MAX        3'h2
`define SCALE_DIGITS      3'h6

`endif

/* File: config_menu_controller.sv */
// Operation
// - rear link closed enters configuration
// - totals then reset held together six seconds enters configuration
// - a setting can disable the key pair entry path
// - run key moves flashing position to next digit
// - display key increments digit or advances to next option
// - batch-set key forces flashing digit to zero
// - stop key advances to next step of the sequence
// - each setup step shows description first, then the value
// - editable value flashes with lamps lit on keys that modify it
// - mode menu setup, batch, option, test, end; display cycles, stop picks
// - stop on end entry exits, only once the link is removed
// - batch-set at clear step zeroes resettable and accumulated totals
// - scaling factor step edited digit by digit
// - rate decimals selectable zero to four
// - timebase per second, minute, hour or day
// - filter constant integer 1 to 99
// - total divisor defaults 1, accepts 0.01 to 2000
// - resettable total decimals zero to two
// - keypad access setting enables or disables key pair entry
//
// Purpose: front panel configuration menu of a batch flow instrument
// Assumes: keys are debounced single-cycle presses except total/reset levels
// Notes:   divisor held in hundredths, BCD digits for the scaling factor
`timescale 1ns/10ps
`default_nettype none

`include "cfg_menu_regs.svh"

module config_menu_controller
    import cfg_menu_pkg::*;
#(
    parameter int HOLD_CYCLES  = `HOLD_CYCLES,
    parameter int FLASH_CYCLES = `FLASH_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // front panel and rear link
    input  wire keys_s       keys,
    input  wire logic        cfg_link,
    // panel outputs
    output panel_s           panel,
    output lamps_s           lamps,
    output logic             in_config,
    output logic             clear_totals,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    step_e       step;
    mode_e       mode;
    logic        show_value;
    logic [2:0]  digit;
    logic [23:0] scale;
    logic [2:0]  rate_dp;
    timebase_e   timebase;
    logic [6:0]  filter;
    logic [23:0] divisor;
    logic [2:0]  tot_dp;
    logic [2:0]  acc_dp;
    logic        keys_off;
    logic [31:0] flash_cnt;
    logic        flash;
    logic        rd_done;
    logic        hold_fire;
    logic        link_q;

    function automatic logic [23:0] bcd_inc(input logic [23:0] v,
                                            input logic [2:0] d);
        logic [3:0] n;
        logic [23:0] r;
        r = v;
        n = v[d*4 +: 4];
        r[d*4 +: 4] = (n == 4'h9) ? 4'h0 : n + 4'h1;
        return r;
    endfunction

    function automatic logic [23:0] bcd_zero(input logic [23:0] v,
                                             input logic [2:0] d);
        logic [23:0] r;
        r = v;
        r[d*4 +: 4] = 4'h0;
        return r;
    endfunction

    //--------------------------------------------------------------
    // entry paths
    //--------------------------------------------------------------
    key_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .mclk      (mclk),
        .resetn    (resetn),
        .total_key (keys.total),
        .reset_key (keys.reset),
        .allow     (!keys_off && step == ST_IDLE),
        .fire      (hold_fire)
    );

    wire link_rise = cfg_link & !link_q;
    wire enter     = (step == ST_IDLE) & (link_rise | hold_fire);
    wire is_digit  = (step == ST_SCALE) | (step == ST_DIVISOR);
    wire is_choice = (step == ST_RATE_DP) | (step == ST_TIMEBASE) |
                     (step == ST_FILTER) | (step == ST_TOT_DP) |
                     (step == ST_ACC_DP) | (step == ST_ACCESS);
    wire editable  = show_value & (is_digit | is_choice);
    wire press_run = keys.run & editable & is_digit;
    wire press_dsp = keys.display & (editable | step == ST_MODE);
    wire press_bs  = keys.batch_set & show_value &
                     (is_digit | step == ST_CLEAR);
    wire press_stp = keys.stop & (step != ST_IDLE);

    //--------------------------------------------------------------
    // step sequencer
    //--------------------------------------------------------------
    logic [3:0] next_step_code;
    step_e      next_step;
    always_comb begin
        next_step = step;
        unique case (step)
            ST_IDLE:     next_step = enter ? ST_MODE : ST_IDLE;
            ST_MODE: begin
                unique case (mode)
                    MODE_SETUP:  next_step = ST_CLEAR;
                    MODE_END:    next_step = cfg_link ? ST_MODE
                                                      : ST_IDLE;
                    default:     next_step = ST_OTHER;
                endcase
            end
            ST_CLEAR:    next_step = ST_SCALE;
            ST_SCALE:    next_step = ST_RATE_DP;
            ST_RATE_DP:  next_step = ST_TIMEBASE;
            ST_TIMEBASE: next_step = ST_FILTER;
            ST_FILTER:   next_step = ST_DIVISOR;
            ST_DIVISOR:  next_step = ST_TOT_DP;
            ST_TOT_DP:   next_step = ST_ACC_DP;
            ST_ACC_DP:   next_step = ST_ACCESS;
            ST_ACCESS:   next_step = ST_MODE;
            ST_OTHER:    next_step = ST_MODE;
        endcase
    end
    assign next_step_code = next_step;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            step       <= ST_IDLE;
            mode       <= MODE_SETUP;
            show_value <= 1'b0;
            digit      <= 3'h0;
            link_q     <= 1'b0;
        end else begin
            link_q <= cfg_link;
            if (enter) begin
                step       <= ST_MODE;
                mode       <= MODE_SETUP;
                show_value <= 1'b0;
            end else if (press_stp && step != ST_MODE && !show_value
                         && step != ST_OTHER) begin
                show_value <= 1'b1;
                digit      <= 3'h0;
            end else if (press_stp) begin
                step       <= next_step;
                show_value <= 1'b0;
                digit      <= 3'h0;
                if (step == ST_MODE && next_step == ST_MODE)
                    mode <= MODE_END;
                else if (next_step == ST_MODE)
                    mode <= MODE_END;
            end else if (press_dsp && step == ST_MODE) begin
                mode <= (mode == MODE_END) ? MODE_SETUP
                                           : mode_e'(mode + 3'h1);
            end else if (press_run) begin
                digit <= (digit == `SCALE_DIGITS - 3'h1) ? 3'h0
                                                         : digit + 3'h1;
            end
        end
    end

    //--------------------------------------------------------------
    // parameter edits
    //--------------------------------------------------------------
    wire [23:0] div_inc  = bcd_inc(divisor, digit);
    wire [23:0] div_zero = bcd_zero(divisor, digit);
    wire [6:0]  filt_inc = (filter == `FILTER_MAX) ? `FILTER_MIN
                                                   : filter + 7'h01;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scale    <= `SCALE_RESET;
            rate_dp  <= 3'h0;
            timebase <= TB_SEC;
            filter   <= `FILTER_RESET;
            divisor  <= `DIVISOR_RESET;
            tot_dp   <= 3'h0;
            acc_dp   <= 3'h0;
            keys_off <= 1'b0;
        end else if (avs_write && !avs_waitrequest
                     && avs_address[5:2] == `ADDR_CTRL) begin
            keys_off <= avs_writedata[`CTRL_KEYS_OFF_BIT];
        end else if (press_dsp) begin
            unique case (step)
                ST_SCALE:    scale <= bcd_inc(scale, digit);
                ST_DIVISOR:  divisor <= div_inc;
                ST_RATE_DP:  rate_dp <= (rate_dp == `RATE_DP_MAX)
                                        ? 3'h0 : rate_dp + 3'h1;
                ST_TIMEBASE: timebase <= timebase_e'(timebase + 2'h1);
                ST_FILTER:   filter <= filt_inc;
                ST_TOT_DP:   tot_dp <= (tot_dp == `TOT_DP_MAX)
                                       ? 3'h0 : tot_dp + 3'h1;
                ST_ACC_DP:   acc_dp <= (acc_dp == `TOT_DP_MAX)
                                       ? 3'h0 : acc_dp + 3'h1;
                ST_ACCESS:   keys_off <= !keys_off;
                default:     ;
            endcase
        end else if (press_bs) begin
            if (step == ST_SCALE)
                scale <= bcd_zero(scale, digit);
            else if (step == ST_DIVISOR)
                divisor <= div_zero;
        end else if (press_stp && step == ST_DIVISOR && show_value
                     && (bcd_bin(divisor) < `DIVISOR_MIN
                         || bcd_bin(divisor) > `DIVISOR_MAX)) begin
            divisor <= `DIVISOR_RESET;
        end
    end

    function automatic logic [23:0] bcd_bin(input logic [23:0] v);
        logic [23:0] r;
        r = 24'h000000;
        for (int i = 5; i >= 0; i--)
            r = 24'(r * 24'd10 + {20'h00000, v[i*4 +: 4]});
        return r;
    endfunction

    //--------------------------------------------------------------
    // clear pulse, flashing and panel
    //--------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)
            clear_totals <= 1'b0;
        else
            clear_totals <= press_bs && step == ST_CLEAR;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flash_cnt <= 32'h00000000;
            flash     <= 1'b0;
        end else if (flash_cnt == 32'(FLASH_CYCLES - 1)) begin
            flash_cnt <= 32'h00000000;
            flash     <= !flash;
        end else begin
            flash_cnt <= flash_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            panel <= '0;
            lamps <= '0;
        end else begin
            panel.step       <= next_step_code & 4'h0 | step;
            panel.show_value <= show_value;
            panel.flash      <= editable & flash;
            panel.digit      <= digit;
            panel.mode       <= mode;
            lamps.run        <= editable & is_digit;
            lamps.display    <= editable;
            lamps.batch_set  <= show_value & (is_digit | step == ST_CLEAR);
            lamps.stop       <= step != ST_IDLE;
        end
    end

    assign in_config = (step != ST_IDLE);

    //--------------------------------------------------------------
    // avalon-mm slave: one wait cycle on reads
    //--------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        unique case (avs_address[5:2])
            `ADDR_CTRL:     rd_mux = {31'h0, keys_off};
            `ADDR_STATUS:   rd_mux = {19'h0, show_value, digit, mode,
                                      4'(step), in_config, 1'b0};
            `ADDR_SCALE:    rd_mux = {8'h00, scale};
            `ADDR_RATE_DP:  rd_mux = {29'h0, rate_dp};
            `ADDR_TIMEBASE: rd_mux = {30'h0, timebase};
            `ADDR_FILTER:   rd_mux = {25'h0, filter};
            `ADDR_DIVISOR:  rd_mux = {8'h00, divisor};
            `ADDR_TOT_DP:   rd_mux = {29'h0, tot_dp};
            `ADDR_ACC_DP:   rd_mux = {29'h0, acc_dp};
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_done      <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_done      <= avs_read & !rd_done;
            avs_readdata <= rd_mux;
        end
    end

    assign avs_waitrequest = avs_read & !rd_done;

endmodule // config_menu_controller

`default_nettype wire

/* File: config_menu_controller_tb_top.sv */
// Purpose: self-checking bench of the configuration menu controller
// Assumes: hold count shortened to HOLD cycles
// Notes:   reads queue their expectations for the monitor
`timescale 1ns/10ps
`default_nettype none

module config_menu_controller_tb_top
    import cfg_menu_pkg::*;
;
    localparam int    HOLD   = 20;
    localparam keys_s K_RUN  = 6'h20;
    localparam keys_s K_DISP = 6'h10;
    localparam keys_s K_BSET = 6'h08;
    localparam keys_s K_STOP = 6'h04;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    keys_s       keys;
    logic        cfg_link, in_config, clear_totals, avs_waitrequest;
    panel_s      panel;
    lamps_s      lamps;
    logic [5:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, rd;
    logic [32:0] notes[$];
    logic [2:0]  d0;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          clears = 0;
    int          k;
    integer      seed = 89;

    config_menu_controller #(.HOLD_CYCLES(HOLD), .FLASH_CYCLES(4)) DUT (
        .mclk(mclk), .resetn(resetn), .keys(keys), .cfg_link(cfg_link),
        .panel(panel), .lamps(lamps), .in_config(in_config),
        .clear_totals(clear_totals), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    front_panel_model u_fp (.mclk(mclk), .keys(keys), .cfg_link(cfg_link));

    always #5 mclk = ~mclk;

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (clear_totals === 1'b1)
            clears <= clears + 1;
        if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            if (notes[0][32])
                check("readdata", avs_readdata, notes[0][31:0]);
            void'(notes.pop_front());
        end
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    // ----------------------------------------
    // bus master and keypad helpers
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                       input logic care);
        notes.push_back({care, e});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic key(input keys_s kk);
        u_fp.press(kk, 3 + ($random(seed) & 3));
    endtask

    // from a shown value, one stop to the next step, a second stop to its value
    task automatic next(input step_e s);
        key(K_STOP);
        check("step", panel.step, s);
        check("desc", panel.show_value, 32'h0);
        key(K_STOP);
        check("value", panel.show_value, 32'h1);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rdc(6'h00, 32'h0, 1'b1);
        rdc(6'h08, 32'h1, 1'b1);
        rdc(6'h14, 32'h1, 1'b1);
        rdc(6'h18, 32'h100, 1'b1);
        bus(1'b1, 6'h3C, $random(seed));
        rdc(6'h3C, 32'h0, 1'b1);
        u_fp.set_link(1'b1);
        repeat (4) @(posedge mclk);
        check("in_config", in_config, 32'h1);
        for (int i = 1; i <= 5; i++) begin
            key(K_DISP);
            check("mode", panel.mode, i % 5);
        end
        next(ST_CLEAR);
        key(K_BSET);
        check("clears", clears, 32'h1);
        next(ST_SCALE);
        check("lamp", lamps.display, 32'h1);
        check("lamp run", lamps.run, 32'h1);
        check("lamp bset", lamps.batch_set, 32'h1);
        d0 = panel.digit;
        key(K_RUN);
        check("digit moved", panel.digit !== d0, 32'h1);
        for (int i = 0; i < 3; i++) key(K_DISP);
        rdc(6'h08, 32'h0, 1'b0);
        k = -1;
        for (int i = 0; i < 6; i++)
            if (rd === 32'h1 + (32'h3 << (4 * i))) k = i;
        check("digit raised", k >= 0, 32'h1);
        if (k < 0) k = 0;
        key(K_BSET);
        rdc(6'h08, rd & ~(32'hF << (4 * k)), 1'b1);
        next(ST_RATE_DP);
        for (int i = 1; i <= 5; i++) begin
            key(K_DISP);
            rdc(6'h0C, i % 5, 1'b1);
        end
        next(ST_TIMEBASE);
        for (int i = 1; i <= 4; i++) begin
            key(K_DISP);
            rdc(6'h10, i % 4, 1'b1);
        end
        next(ST_FILTER);
        key(K_DISP);
        rdc(6'h14, 32'h2, 1'b1);
        next(ST_DIVISOR);
        key(K_RUN);
        key(K_RUN);
        key(K_BSET);
        rdc(6'h18, 32'h0, 1'b1);
        next(ST_TOT_DP);
        rdc(6'h18, 32'h100, 1'b1);
        for (int i = 1; i <= 3; i++) begin
            key(K_DISP);
            rdc(6'h1C, i % 3, 1'b1);
        end
        next(ST_ACC_DP);
        next(ST_ACCESS);
        key(K_DISP);
        rdc(6'h00, 32'h1, 1'b1);
        key(K_STOP);
        check("end shown", panel.mode, MODE_END);
        key(K_STOP);
        check("link held", in_config, 32'h1);
        u_fp.set_link(1'b0);
        key(K_STOP);
        check("exit", in_config, 32'h0);
        u_fp.hold_pair(HOLD + 10);
        repeat (4) @(posedge mclk);
        check("pair locked", in_config, 32'h0);
        bus(1'b1, 6'h00, 32'h0);
        u_fp.hold_pair(HOLD - 5);
        u_fp.hold_pair(HOLD - 5);
        repeat (4) @(posedge mclk);
        check("pair restart", in_config, 32'h0);
        u_fp.hold_pair(HOLD + 5);
        repeat (4) @(posedge mclk);
        check("pair entry", in_config, 32'h1);
        key(K_DISP);
        key(K_STOP);
        check("other mode", panel.step, ST_OTHER);
        key(K_STOP);
        check("end shown", panel.mode, MODE_END);
        key(K_STOP);
        check("exit", in_config, 32'h0);
        summarize();
    end
endmodule // config_menu_controller_tb_top

`default_nettype wire

/* File: config_menu_properties.sv */
// Purpose: port-level checks of the configuration menu controller
// Assumes: one clock domain, bound to the top module
// Notes:   hold count handed on from the bound instance
`timescale 1ns/10ps
`default_nettype none

module config_menu_properties
    import cfg_menu_pkg::*;
#(
    parameter int HOLD_CYCLES  = 20,
    parameter int FLASH_CYCLES = 4
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // panel side
    input  wire keys_s       keys,
    input  wire logic        cfg_link,
    input  wire panel_s      panel,
    input  wire lamps_s      lamps,
    input  wire logic        in_config,
    input  wire logic        clear_totals,
    // register bus
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    logic [31:0] pair_cnt;

    // consecutive cycles with both keys of the pair held
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)
            pair_cnt <= '0;
        else if (keys.total && keys.reset)
            pair_cnt <= pair_cnt + 32'h1;
        else
            pair_cnt <= '0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_read_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_key_entry;
        $rose(in_config) && !cfg_link && !$past(cfg_link);
    endsequence

    a_link_entry: assert property (
        !in_config && $rose(cfg_link) |-> ##[1:2] in_config)
        else $error("link closure did not enter configuration");
    a_pair_hold: assert property (
        s_key_entry |-> pair_cnt >= HOLD_CYCLES - 1)
        else $error("key pair entry before the hold period");
    a_step_by_stop: assert property (
        in_config && $past(in_config, 3) && $changed(panel.step)
        |-> $past(keys.stop) || $past(keys.stop, 2))
        else $error("step changed without the stop key");
    a_desc_first: assert property (
        in_config && $changed(panel.step)
        && panel.step inside {[4'h2:4'hA]} |-> !panel.show_value)
        else $error("new step did not open on its description");
    a_flash_lamp: assert property (
        panel.flash && $past(panel.flash) |-> lamps.display)
        else $error("flashing value without display lamp");
    a_mode_range: assert property (
        in_config |-> panel.mode <= 3'h4)
        else $error("mode outside the menu");
    a_exit_rule: assert property (
        $fell(in_config) |-> !$past(cfg_link) && $past(keys.stop))
        else $error("left configuration wrongly");
    a_clear_cause: assert property (
        $rose(clear_totals) |-> panel.step == ST_CLEAR
        && ($past(keys.batch_set) || $past(keys.batch_set, 2)))
        else $error("totals cleared without batch-set at clear step");
    a_clear_pulse: assert property (
        clear_totals |=> !clear_totals)
        else $error("clear pulse longer than one cycle");
    a_read_wait: assert property (
        $rose(avs_read) |-> s_read_answer)
        else $error("read answer not after one wait cycle");
    a_write_nowait: assert property (
        avs_write |-> !avs_waitrequest)
        else $error("write stalled");
endmodule // config_menu_properties

bind config_menu_controller config_menu_properties #(
    .HOLD_CYCLES(HOLD_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_props (
    .mclk(mclk), .resetn(resetn), .keys(keys), .cfg_link(cfg_link),
    .panel(panel), .lamps(lamps), .in_config(in_config),
    .clear_totals(clear_totals), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

`default_nettype wire

/* File: front_panel_model.sv */
// Purpose: keypad and rear link as seen by the controller
// Assumes: keys arrive debounced and synchronous to mclk
// Notes:   driven through its tasks by the testbench
`timescale 1ns/10ps
`default_nettype none

module front_panel_model
    import cfg_menu_pkg::*;
(
    // clock
    input  wire logic mclk,
    // towards the controller
    output var keys_s keys,
    output var logic  cfg_link
);
    initial begin
        keys     = '0;
        cfg_link = 1'b0;
    end

    // one-cycle press, then a settle gap
    task automatic press(input keys_s k, input int gap);
        @(posedge mclk);
        keys <= k;
        @(posedge mclk);
        keys <= '0;
        repeat (gap) @(posedge mclk);
    endtask

    // totals and reset pressed together and held n cycles, then both let go
    task automatic hold_pair(input int n);
        @(posedge mclk);
        keys <= 6'h03;
        repeat (n) @(posedge mclk);
        keys <= '0;
    endtask

    task automatic set_link(input logic v);
        @(posedge mclk);
        cfg_link <= v;
    endtask
endmodule // front_panel_model

`default_nettype wire

/* File: key_hold_timer.sv */
// Purpose: times the totals + reset key pair hold for keypad entry
// Assumes: keys already debounced and synchronous to mclk
// Notes:   fires once per hold, re-arms when a key is let go
`timescale 1ns/10ps
`default_nettype none

`include "cfg_menu_regs.svh"

module key_hold_timer #(
    parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // keys
    input  wire logic total_key,
    input  wire logic reset_key,
    input  wire logic allow,
    // result
    output logic      fire
);

    logic [31:0] count;
    logic        done;
    wire         both = total_key & reset_key & allow;
    wire         last = (count == 32'(HOLD_CYCLES - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= 32'h00000000;
            done  <= 1'b0;
        end else if (!both) begin
            count <= 32'h00000000;
            done  <= 1'b0;
        end else if (!done) begin
            count <= last ? 32'h00000000 : count + 32'h00000001;
            done  <= last;
        end
    end

    assign fire = both & !done & last;

endmodule // key_hold_timer

`default_nettype wire
